// ==== logic/tte_exec.sv ====
// How it works
// - Opcode 6e with immediate byte loads that byte into the accumulator.
// - Immediate load: byte to bits 7-0; bits 13-8 sign copy or zero by mode.
// - Opcode 62 copies the immediate byte unchanged into the index register.
// - Indexed memory load into accumulator, sign-extended or zero-filled by mode.
// - Opcode 69 loads memory at operand address, same extension as indexed load.
// - Opcode 14 loads memory at index with extension, then increments index.
// - Opcode 6f copies low eight bits of memory at operand into index.
// - Random read copies eight random bits into accumulator, never sign-extended.
// - Random register clears to zero at reset; the xor feedback of zero is zero, so it stays at zero.
// - Every instruction cycle random shifts left, bit 0 gets bit13 xor bit14.
// - Random read takes the value from before that cycle's shift.
// - Accumulator mask test sets flag when acc AND byte equals byte.
// - Opcode 66 sets flag when all byte bits are set in memory at index.
// - Opcode 17 loads timer into accumulator with mode-dependent upper bits.
// - Opcode 10 loads index into accumulator with mode-dependent upper bits.
// - Opcode 12 swaps the full B register and accumulator.
// - Index swap: B to index, index to B with mode-dependent upper bits.
// - Opcode 61 sets flag when index is greater than or equal to byte.
// - Every transfer and exchange of the group sets the flag to one.
`timescale 1ns/10ps
`default_nettype none
module tte_exec #(
  parameter int unsigned RAM_AW = 8
) (
  input  wire logic                         clk,
  input  wire logic                         rst_n,
  input  wire logic                         ce,
  input  wire logic                         instr_valid,
  input  wire tte_pkg::tte_instr_s          instr,
  input  wire logic                         ext_sign_mode,
  input  wire logic [7:0]                   timer_value,
  input  wire logic                         mem_wr_en,
  input  wire logic [RAM_AW-1:0]            mem_wr_addr,
  input  wire logic [tte_pkg::MEM_W-1:0]    mem_wr_data,
  output logic                              instr_ready,
  output logic                              done_q,
  output logic                              illegal_q,
  output tte_pkg::tte_regs_s                regs_q,
  output logic [14:0]                       random_q
);
  // ----------------------------------------
  // Helper functions
  // ----------------------------------------
  // Widen a byte to the accumulator width per arithmetic mode
  function automatic logic [13:0] widen(input logic [7:0] v, input logic sx);
    widen = {{6{sx & v[7]}}, v};
  endfunction

  // True when every set bit of mask is also set in value
  function automatic logic mask_hit(input logic [7:0] value, input logic [7:0] mask);
    mask_hit = ((value & mask) == mask);
  endfunction

  // Sign-extend or zero-fill a memory word to the accumulator width
  function automatic logic [13:0] widen_mem(input logic [11:0] v, input logic sx);
    widen_mem = {{2{sx & v[11]}}, v};
  endfunction

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  tte_pkg::tte_state_e   state_q;
  tte_pkg::tte_instr_s   cur_q;
  logic [RAM_AW-1:0]     rd_addr;
  logic [11:0]           mem_word;
  logic                  rnd_step;
  logic                  is_mem_op;
  logic [13:0]           acc_d;
  logic [13:0]           b_d;
  logic [7:0]            idx_d;
  logic                  sf_d;
  logic                  known;
  logic [13:0]           acc_q;
  logic [13:0]           b_q;
  logic [7:0]            idx_q;
  logic                  sf_q;

  // Memory opcodes need one fetch cycle through the registered RAM read
  always_comb begin
    is_mem_op = (instr.opcode == tte_pkg::OP_LOAD_MEM_INDEXED)  ||
                (instr.opcode == tte_pkg::OP_LOAD_MEM_DIRECT)   ||
                (instr.opcode == tte_pkg::OP_LOAD_MEM_POST_INC) ||
                (instr.opcode == tte_pkg::OP_LOAD_MEM_TO_INDEX) ||
                (instr.opcode == tte_pkg::OP_MASK_TEST_MEMORY);
  end

  // Fetch addresses the RAM from the latched instruction, so the request may drop after it is taken
  // Direct forms address by operand, the rest by index
  always_comb begin
    if (cur_q.opcode == tte_pkg::OP_LOAD_MEM_DIRECT) begin
      rd_addr = RAM_AW'(cur_q.operand);
    end else if (cur_q.opcode == tte_pkg::OP_LOAD_MEM_TO_INDEX) begin
      rd_addr = RAM_AW'(cur_q.operand);
    end else begin
      rd_addr = RAM_AW'(regs_q.index);
    end
  end

  assign instr_ready = (state_q == tte_pkg::TTE_IDLE);

  // ----------------------------------------
  // Data memory
  // ----------------------------------------
  tte_ram #(
    .AW (RAM_AW),
    .DW (tte_pkg::MEM_W)
  ) u_ram (
    .clk       (clk),
    .ce        (ce),
    .wr_en     (mem_wr_en),
    .wr_addr   (mem_wr_addr),
    .wr_data   (mem_wr_data),
    .rd_addr   (rd_addr),
    .rd_data_q (mem_word)
  );

  // ----------------------------------------
  // Random number generator
  // ----------------------------------------
  // One step per completed instruction cycle
  assign rnd_step = (state_q == tte_pkg::TTE_EXEC);

  tte_lfsr u_lfsr (
    .clk   (clk),
    .rst_n (rst_n),
    .ce    (ce),
    .step  (rnd_step),
    .rnd_q (random_q)
  );

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  // Idle takes an instruction; memory forms pass through fetch
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_q <= tte_pkg::TTE_IDLE;
    end else if (ce) begin
      case (state_q)
        tte_pkg::TTE_IDLE: begin
          if (instr_valid && is_mem_op) begin
            state_q <= tte_pkg::TTE_FETCH;
          end else if (instr_valid) begin
            state_q <= tte_pkg::TTE_EXEC;
          end
        end
        tte_pkg::TTE_FETCH: begin
          state_q <= tte_pkg::TTE_EXEC;
        end
        tte_pkg::TTE_EXEC: begin
          state_q <= tte_pkg::TTE_IDLE; // Ready again with the completion pulse
        end
        default: begin
          state_q <= tte_pkg::TTE_IDLE;
        end
      endcase
    end
  end

  // Latch the instruction as it is taken
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cur_q <= '0;
    end else if (ce && instr_ready && instr_valid) begin
      cur_q <= instr;
    end
  end

  // ----------------------------------------
  // Execute: next register values
  // ----------------------------------------
  always_comb begin
    acc_d = regs_q.accum;
    b_d   = regs_q.breg;
    idx_d = regs_q.index;
    sf_d  = regs_q.status_flag;
    known = 1'b1;
    case (cur_q.opcode)
      // Immediate transfers
      tte_pkg::OP_LOAD_IMM_ACCUM: begin
        acc_d = widen(cur_q.operand, ext_sign_mode);
        sf_d  = 1'b1;
      end
      tte_pkg::OP_LOAD_IMM_INDEX: begin
        idx_d = cur_q.operand;
        sf_d  = 1'b1;
      end
      // Memory transfers, word fetched in the cycle before
      tte_pkg::OP_LOAD_MEM_INDEXED: begin
        acc_d = widen_mem(mem_word, ext_sign_mode);
        sf_d  = 1'b1;
      end
      tte_pkg::OP_LOAD_MEM_DIRECT: begin
        acc_d = widen_mem(mem_word, ext_sign_mode);
        sf_d  = 1'b1;
      end
      tte_pkg::OP_LOAD_MEM_POST_INC: begin
        acc_d = widen_mem(mem_word, ext_sign_mode);
        idx_d = regs_q.index + 8'h01;
        sf_d  = 1'b1;
      end
      tte_pkg::OP_LOAD_MEM_TO_INDEX: begin
        idx_d = mem_word[7:0];
        sf_d  = 1'b1;
      end
      // Random read and mask tests
      tte_pkg::OP_READ_RANDOM: begin
        // Register still holds the pre-shift value this cycle
        acc_d = {6'h00, random_q[7:0]};
        sf_d  = 1'b1;
      end
      tte_pkg::OP_MASK_TEST_ACCUM: begin
        sf_d = mask_hit(regs_q.accum[7:0], cur_q.operand);
      end
      tte_pkg::OP_MASK_TEST_MEMORY: begin
        sf_d = mask_hit(mem_word[7:0], cur_q.operand);
      end
      // Timer and index moves into the accumulator
      tte_pkg::OP_READ_TIMER: begin
        acc_d = widen(timer_value, ext_sign_mode);
        sf_d  = 1'b1;
      end
      tte_pkg::OP_INDEX_TO_ACCUM: begin
        acc_d = widen(regs_q.index, ext_sign_mode);
        sf_d  = 1'b1;
      end
      // Exchanges read only the old register values
      tte_pkg::OP_SWAP_B_ACCUM: begin
        acc_d = regs_q.breg;
        b_d   = regs_q.accum;
        sf_d  = 1'b1;
      end
      tte_pkg::OP_SWAP_B_INDEX: begin
        idx_d = regs_q.breg[7:0];
        b_d   = widen(regs_q.index, ext_sign_mode);
        sf_d  = 1'b1;
      end
      // Unsigned index compare
      tte_pkg::OP_INDEX_GE_COMPARE: begin
        sf_d = (regs_q.index >= cur_q.operand);
      end
      // Outside the group: registers keep their values
      default: begin
        known = 1'b0;
      end
    endcase
  end

  // ----------------------------------------
  // Architectural registers
  // ----------------------------------------
  // Accumulator; all destinations commit on the same execute edge
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      acc_q <= tte_pkg::ACC_RST;
    end else if (ce && state_q == tte_pkg::TTE_EXEC) begin
      acc_q <= acc_d;
    end
  end

  // B register
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      b_q <= tte_pkg::B_RST;
    end else if (ce && state_q == tte_pkg::TTE_EXEC) begin
      b_q <= b_d;
    end
  end

  // Index register
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      idx_q <= tte_pkg::IDX_RST;
    end else if (ce && state_q == tte_pkg::TTE_EXEC) begin
      idx_q <= idx_d;
    end
  end

  // Status flag
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sf_q <= tte_pkg::SF_RST;
    end else if (ce && state_q == tte_pkg::TTE_EXEC) begin
      sf_q <= sf_d;
    end
  end

  // Register view handed to the outside
  assign regs_q = '{accum: acc_q, breg: b_q, index: idx_q, status_flag: sf_q};

  // Completion pulse, raised on the same edge as the registers commit
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      done_q <= 1'b0;
    end else if (ce) begin
      done_q <= (state_q == tte_pkg::TTE_EXEC);
    end
  end

  // Marks an executed opcode that lies outside the group
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      illegal_q <= 1'b0;
    end else if (ce) begin
      illegal_q <= (state_q == tte_pkg::TTE_EXEC) && !known;
    end
  end
endmodule
`default_nettype wire

// ==== logic/tte_lfsr.sv ====
`timescale 1ns/10ps
`default_nettype none
module tte_lfsr (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        ce,
  input  wire logic        step,
  output logic      [14:0] rnd_q
);
  // ----------------------------------------
  // Shift left, feedback from bits 13 and 14
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rnd_q <= tte_pkg::RND_RST;
    end else if (ce && step) begin
      rnd_q <= {rnd_q[13:0],
                rnd_q[tte_pkg::RND_TAP_LO] ^ rnd_q[tte_pkg::RND_TAP_HI]};
    end
  end
endmodule
`default_nettype wire

// ==== logic/tte_pkg.sv ====
`default_nettype none
package tte_pkg;
  // ----------------------------------------
  // Widths
  // ----------------------------------------
  localparam int unsigned ACC_W  = 14;
  localparam int unsigned BYTE_W = 8;
  localparam int unsigned RND_W  = 15;
  localparam int unsigned MEM_W  = 12;

  // ----------------------------------------
  // Opcodes of the group
  // ----------------------------------------
  localparam logic [7:0] OP_LOAD_IMM_ACCUM        = 8'h6e;
  localparam logic [7:0] OP_LOAD_IMM_INDEX        = 8'h62;
  localparam logic [7:0] OP_LOAD_MEM_INDEXED      = 8'h11;
  localparam logic [7:0] OP_LOAD_MEM_DIRECT       = 8'h69;
  localparam logic [7:0] OP_LOAD_MEM_POST_INC     = 8'h14;
  localparam logic [7:0] OP_LOAD_MEM_TO_INDEX     = 8'h6f;
  localparam logic [7:0] OP_READ_RANDOM           = 8'h2b;
  localparam logic [7:0] OP_MASK_TEST_ACCUM       = 8'h6b;
  localparam logic [7:0] OP_MASK_TEST_MEMORY      = 8'h66;
  localparam logic [7:0] OP_READ_TIMER            = 8'h17;
  localparam logic [7:0] OP_INDEX_TO_ACCUM        = 8'h10;
  localparam logic [7:0] OP_SWAP_B_ACCUM          = 8'h12;
  localparam logic [7:0] OP_SWAP_B_INDEX          = 8'h13;
  localparam logic [7:0] OP_INDEX_GE_COMPARE      = 8'h61;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [13:0] ACC_RST  = 14'h0000;
  localparam logic [13:0] B_RST    = 14'h0000;
  localparam logic [7:0]  IDX_RST  = 8'h00;
  localparam logic [14:0] RND_RST  = 15'h0000;
  localparam logic        SF_RST   = 1'b1;

  // ----------------------------------------
  // Random register taps and feedback
  // ----------------------------------------
  localparam int unsigned RND_TAP_LO = 13;
  localparam int unsigned RND_TAP_HI = 14;

  // Instruction word presented with its operand byte
  typedef struct packed {
    logic [7:0] opcode;
    logic [7:0] operand;
  } tte_instr_s;

  // Architectural register view
  typedef struct packed {
    logic [13:0] accum;
    logic [13:0] breg;
    logic [7:0]  index;
    logic        status_flag;
  } tte_regs_s;

  // Execution phases
  typedef enum logic [1:0] {
    TTE_IDLE  = 2'b00,
    TTE_FETCH = 2'b01,
    TTE_EXEC  = 2'b10
  } tte_state_e;
endpackage
`default_nettype wire

// ==== logic/tte_ram.sv ====
`timescale 1ns/10ps
`default_nettype none
module tte_ram #(
  parameter int unsigned AW = 8,
  parameter int unsigned DW = 12
) (
  input  wire logic          clk,
  input  wire logic          ce,
  input  wire logic          wr_en,
  input  wire logic [AW-1:0] wr_addr,
  input  wire logic [DW-1:0] wr_data,
  input  wire logic [AW-1:0] rd_addr,
  output logic      [DW-1:0] rd_data_q
);
  logic [DW-1:0] mem [0:(1<<AW)-1];

  // ----------------------------------------
  // Write port
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (ce && wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  // ----------------------------------------
  // Registered read port
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (ce) begin
      rd_data_q <= mem[rd_addr];
    end
  end
endmodule
`default_nettype wire

// ==== verif/tb_top.sv ====
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic               clk, rst_n, ce, instr_valid, ext_sign_mode, mem_wr_en;
  tte_pkg::tte_instr_s instr;
  logic [7:0]         timer_value, mem_wr_addr;
  logic [11:0]        mem_wr_data;
  logic               instr_ready, done_q, illegal_q, ill;
  tte_pkg::tte_regs_s  regs_q, s;
  logic [14:0]        random_q, r;
  int                 n_fail, tests_run, cyc;

  tte_exec dut (.clk(clk), .rst_n(rst_n), .ce(ce), .instr_valid(instr_valid), .instr(instr),
    .ext_sign_mode(ext_sign_mode), .timer_value(timer_value), .mem_wr_en(mem_wr_en), .mem_wr_addr(mem_wr_addr),
    .mem_wr_data(mem_wr_data), .instr_ready(instr_ready), .done_q(done_q), .illegal_q(illegal_q),
    .regs_q(regs_q), .random_q(random_q));

  // ----------------------------------------
  // Clock and watchdog
  // ----------------------------------------
  always #10 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_fail++;
      final_report();
    end
  end

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic chk(input string nm, input logic [14:0] exp, input logic [14:0] got);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic chk_bit(input string nm, input logic exp, input logic got);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch %s expected %b seen %b", nm, exp, got);
    end
  endtask
  function automatic logic [14:0] x8(input logic [7:0] b, input logic m);
    return m ? {7'h00, {6{b[7]}}, b} : {7'h00, b};
  endfunction
  function automatic logic [14:0] x12(input logic [11:0] w, input logic m);
    return m ? {3'h0, {2{w[11]}}, w} : {3'h0, w};
  endfunction
  // One instruction, then wait for its completion pulse
  task automatic run(input logic [7:0] op, input logic [7:0] arg);
    int n;
    instr = {op, arg};
    instr_valid = 1'b1;
    @(posedge clk);
    #1 instr_valid = 1'b0;
    n = 0;
    while (done_q !== 1'b1 && n < 8) begin
      @(posedge clk);
      #1 n++;
    end
    ill = illegal_q;
    chk_bit("done", 1'b1, done_q);
  endtask
  task automatic wr(input logic [7:0] a, input logic [11:0] d);
    mem_wr_en = 1'b1;
    mem_wr_addr = a;
    mem_wr_data = d;
    @(posedge clk);
    #1 mem_wr_en = 1'b0;
    @(posedge clk);
    #1;
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset;
    chk("accum", 15'h0000, regs_q.accum);
    chk("index", 15'h0000, regs_q.index);
    chk("random", 15'h0000, random_q);
    chk_bit("ready", 1'b1, instr_ready);
  endtask
  task automatic t_imm;
    for (int m = 0; m < 2; m++) begin
      ext_sign_mode = m[0];
      run(8'h6b, 8'hff);
      chk_bit("flag", 1'b0, regs_q.status_flag);
      run(8'h6e, 8'h85);
      chk("accum", x8(8'h85, m[0]), regs_q.accum);
      chk_bit("flag", 1'b1, regs_q.status_flag);
    end
  endtask
  task automatic t_mem;
    wr(8'h20, 12'h9a5);
    wr(8'h21, 12'h8c3);
    for (int m = 0; m < 2; m++) begin
      ext_sign_mode = m[0];
      run(8'h69, 8'h20);
      chk("accum", x12(12'h9a5, m[0]), regs_q.accum);
      run(8'h62, 8'h21);
      run(8'h11, 8'h00);
      chk("accum", x12(12'h8c3, m[0]), regs_q.accum);
      run(8'h62, 8'h20);
      run(8'h14, 8'h00);
      chk("accum", x12(12'h9a5, m[0]), regs_q.accum);
      chk("index", 15'h0021, regs_q.index);
    end
    run(8'h6f, 8'h21);
    chk("index", 15'h00c3, regs_q.index);
  endtask
  task automatic t_mask;
    run(8'h62, 8'h20);
    run(8'h66, 8'h85);
    chk_bit("flag", 1'b1, regs_q.status_flag);
    run(8'h66, 8'h5a);
    chk_bit("flag", 1'b0, regs_q.status_flag);
    run(8'h6e, 8'hf5);
    run(8'h6b, 8'h0a);
    chk_bit("flag", 1'b0, regs_q.status_flag);
    run(8'h6b, 8'hf0);
    chk_bit("flag", 1'b1, regs_q.status_flag);
    chk("accum", x8(8'hf5, ext_sign_mode), regs_q.accum);
  endtask
  task automatic t_timer_index;
    for (int m = 0; m < 2; m++) begin
      ext_sign_mode = m[0];
      timer_value = 8'h9c;
      run(8'h17, 8'h00);
      chk("accum", x8(8'h9c, m[0]), regs_q.accum);
      run(8'h62, 8'hb1);
      run(8'h10, 8'h00);
      chk("accum", x8(8'hb1, m[0]), regs_q.accum);
    end
  endtask
  task automatic t_swap;
    run(8'h6e, 8'h7a);
    run(8'h12, 8'h00);
    chk("accum", 15'h0000, regs_q.accum);
    chk("breg", 15'h007a, regs_q.breg);
    run(8'h62, 8'hc4);
    run(8'h13, 8'h00);
    chk("index", 15'h007a, regs_q.index);
    chk("breg", 15'h3fc4, regs_q.breg);
    ext_sign_mode = 1'b0;
    run(8'h13, 8'h00);
    chk("index", 15'h00c4, regs_q.index);
    chk("breg", 15'h007a, regs_q.breg);
  endtask
  task automatic t_random;
    ext_sign_mode = 1'b1;
    run(8'h6e, 8'hff);
    r = random_q;
    run(8'h2b, 8'h00);
    chk("accum", {7'h00, r[7:0]}, regs_q.accum);
    chk("random", {r[13:0], r[13] ^ r[14]}, random_q);
  endtask
  task automatic t_compare;
    run(8'h61, 8'hc4);
    chk_bit("flag", 1'b1, regs_q.status_flag);
    run(8'h61, 8'hc5);
    chk_bit("flag", 1'b0, regs_q.status_flag);
    run(8'h61, 8'h00);
    chk_bit("flag", 1'b1, regs_q.status_flag);
  endtask
  task automatic t_illegal_freeze;
    s = regs_q;
    run(8'hff, 8'h00);
    chk_bit("illegal", 1'b1, ill);
    chk("accum", s.accum, regs_q.accum);
    @(posedge clk);
    #1 ce = 1'b0;
    instr = {8'h6e, 8'h55};
    instr_valid = 1'b1;
    repeat (4) @(posedge clk);
    #1 chk_bit("done", 1'b0, done_q);
    chk("accum", s.accum, regs_q.accum);
    ce = 1'b1;
    run(8'h6e, 8'h55);
    chk("accum", 15'h0055, regs_q.accum);
  endtask

  task automatic final_report;
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    {clk, rst_n, instr_valid, ext_sign_mode, mem_wr_en} = 5'h00;
    ce = 1'b1;
    instr = 16'h0000;
    {timer_value, mem_wr_addr, mem_wr_data} = 28'h0000000;
    {n_fail, tests_run, cyc} = '0;
    repeat (12) @(posedge clk);
    #1 rst_n = 1'b1;
    t_reset();
    t_imm();
    t_mem();
    t_mask();
    t_timer_index();
    t_swap();
    t_random();
    t_compare();
    t_illegal_freeze();
    final_report();
  end
endmodule
`default_nettype wire

// ==== verif/tte_exec_checker.sv ====
`timescale 1ns/10ps
`default_nettype none
module tte_exec_checker (
  input wire logic               clk,
  input wire logic               rst_n,
  input wire logic               ce,
  input wire logic               instr_valid,
  input wire tte_pkg::tte_instr_s instr,
  input wire logic               instr_ready,
  input wire logic               done_q,
  input wire logic               illegal_q,
  input wire tte_pkg::tte_regs_s  regs_q,
  input wire logic [14:0]        random_q
);
  // ----------------------------------------
  // Helper state
  // ----------------------------------------
  logic               take;
  logic [7:0]         op_q;
  logic [7:0]         arg_q;
  tte_pkg::tte_regs_s pre_q;

  assign take = ce && instr_valid && instr_ready;

  // Keep the accepted request and the registers seen before it
  always_ff @(posedge clk) begin
    if (take) begin
      op_q  <= instr.opcode;
      arg_q <= instr.operand;
      pre_q <= regs_q;
    end
  end

  // Opcodes that wait for a memory word
  function automatic logic is_mem(input logic [7:0] op);
    return op inside {8'h11, 8'h69, 8'h14, 8'h6f, 8'h66};
  endfunction

  // Transfers and exchanges, which always leave the flag set
  function automatic logic is_xfer(input logic [7:0] op);
    return op inside {8'h6e, 8'h62, 8'h11, 8'h69, 8'h14, 8'h6f, 8'h2b, 8'h17, 8'h10, 8'h12, 8'h13};
  endfunction

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_take;
    take;
  endsequence
  sequence s_reg_done;
    !done_q ##1 done_q;
  endsequence
  sequence s_mem_done;
    !done_q [*2] ##1 done_q;
  endsequence

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  a_reg_latency: assert property (s_take ##0 !is_mem(instr.opcode) |=> s_reg_done)
    else $error("register op done at wrong cycle");
  a_mem_latency: assert property (s_take ##0 is_mem(instr.opcode) |=> s_mem_done)
    else $error("memory op done at wrong cycle");
  a_done_pulse: assert property (done_q |=> !done_q)
    else $error("done longer than one cycle");
  a_busy_after_take: assert property (take |=> !instr_ready)
    else $error("ready while executing");
  a_flag_transfer: assert property (done_q && !illegal_q && is_xfer(op_q) |-> regs_q.status_flag)
    else $error("flag clear after transfer");
  a_swap_old_values: assert property (done_q && op_q == 8'h12 |-> regs_q.accum == pre_q.breg && regs_q.breg == pre_q.accum)
    else $error("accumulator swap wrong");
  a_post_increment: assert property (done_q && op_q == 8'h14 |-> regs_q.index == pre_q.index + 8'h01)
    else $error("index not incremented");
  a_index_imm: assert property (done_q && op_q == 8'h62 |-> regs_q.index == arg_q)
    else $error("index load wrong");
  a_illegal_keeps: assert property (illegal_q |-> done_q && regs_q == pre_q)
    else $error("illegal op changed registers");
  a_random_shift: assert property ($rose(done_q) |-> random_q == {$past(random_q[13:0]), $past(random_q[13]) ^ $past(random_q[14])})
    else $error("random step wrong");
  a_freeze: assert property (!ce |=> $stable(regs_q) && $stable(random_q))
    else $error("state moved while disabled");
endmodule

bind tte_exec tte_exec_checker u_chk (.clk(clk), .rst_n(rst_n), .ce(ce), .instr_valid(instr_valid), .instr(instr),
  .instr_ready(instr_ready), .done_q(done_q), .illegal_q(illegal_q), .regs_q(regs_q), .random_q(random_q));
`default_nettype wire
